// file: bench/self_program_flash_sequencer_tb.sv
// self-checking bench: software over axi4-lite drives the core end into the sequencer
`timescale 1ns/10ps
module self_program_flash_sequencer_tb;
   import spf_pkg::*;
   logic        aclk, aresetn, osc_tick, flash_we, flash_erase;
   logic [23:0] flash_rdata, flash_addr, flash_wdata, fl_wd;
   logic [3:0]  flash_op, wstrb, fl_op;
   logic [7:0]  awaddr, araddr, fl_pg;
   logic [31:0] wdata, rdata, d;
   logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, r;
   int          miscompares, n_tests, n_fl, prev;
   logic [15:0] ops [4] = '{16'hc001, 16'hc003, 16'hc042, 16'hc040};
   spf_if spf_if_i (.aclk(aclk));
   spf_core spf_core_i (.aclk(aclk), .aresetn(aresetn), .link(spf_if_i), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   spf_device spf_device_i (.aclk(aclk), .aresetn(aresetn), .link(spf_if_i), .osc_tick(osc_tick),
      .flash_we(flash_we), .flash_erase(flash_erase), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
      .flash_op(flash_op), .flash_rdata(flash_rdata));
   spf_properties spf_properties_i (.aclk(aclk), .aresetn(aresetn), .cmd_valid(spf_if_i.cmd_valid),
      .cmd(spf_if_i.cmd), .byte_mode(spf_if_i.byte_mode), .cmd_data(spf_if_i.cmd_data), .stall(spf_if_i.stall),
      .rd_valid(spf_if_i.rd_valid), .rd_data(spf_if_i.rd_data), .ctl_status(spf_if_i.ctl_status));
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // record every array write or erase the device launches
   always @(posedge aclk)
   begin
      if (flash_we || flash_erase)
      begin
         n_fl++;
         fl_op = flash_op;
         fl_pg = flash_addr[23:16];
         if (flash_we)
            fl_wd = flash_wdata;
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
      logic got;
      got = 1'b0;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= v;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!got)
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid === 1'b1)
         begin
            rsp = bresp;
            bready <= 1'b0;
            got = 1'b1;
         end
      end
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
      logic got;
      got = 1'b0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!got)
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid === 1'b1)
         begin
            v = rdata;
            rsp = rresp;
            rready <= 1'b0;
            got = 1'b1;
         end
      end
   endtask : axi_rd
   // settle time covers the link walk: command pulse, device reaction and table stall
   task automatic link_cmd(input spf_cmd_t c, input logic [15:0] v);
      logic [1:0] rsp;
      axi_wr(REG_CMD, {v, 11'h000, 1'b0, 1'b0, c}, rsp);
      check("command bresp", {30'h0, rsp}, 32'h0);
      repeat (4) @(posedge aclk);
   endtask : link_cmd
   task automatic wait_idle();
      do
         axi_rd(REG_STATUS, d, r);
      while (d[16] !== 1'b0);
   endtask : wait_idle
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   initial
   begin
      repeat (90000) @(posedge aclk);
      miscompares++;
      $display("watchdog expired");
      wrap_up();
   end
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      osc_tick = 1'b1;
      wstrb = 4'hf;
      flash_rdata = 24'ha5c3e1;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(REG_STATUS, d, r);
      check("status after reset", d, 32'h0);
      axi_rd(8'h10, d, r);
      check("unmapped read resp", {30'h0, r}, 32'h2);
      axi_wr(REG_STATUS, 32'h8000_0005, r);
      check("refused write resp", {30'h0, r}, 32'h2);
      $display("test reset and refusals done");
      link_cmd(SPF_CMD_PAGE, 16'h0012);
      link_cmd(SPF_CMD_RD_LO, 16'h0100);
      axi_rd(REG_RDATA, d, r);
      check("read low word", d[15:0], 16'hc3e1);
      link_cmd(SPF_CMD_RD_HI, 16'h0100);
      axi_rd(REG_RDATA, d, r);
      check("read high byte", d[15:0], 16'h00a5);
      link_cmd(SPF_CMD_KEY_WR, {8'h00, KEY_FIRST});
      axi_rd(REG_RDATA, d, r);
      check("key not readable", d[15:0], 16'h00a5);
      axi_wr(REG_CMD, {16'h0101, 11'h000, 1'b1, 1'b0, SPF_CMD_RD_LO}, r);
      repeat (4) @(posedge aclk);
      axi_rd(REG_RDATA, d, r);
      check("read low byte odd", d[15:0], 16'h00c3);
      $display("test table reads done");
      for (int i = 0; i < 3; i++)
      begin
         if (i > 0)
            link_cmd(SPF_CMD_KEY_WR, {8'h00, KEY_FIRST});
         if (i == 1)
            link_cmd(SPF_CMD_PAGE, 16'h0012);
         if (i > 0)
            link_cmd(SPF_CMD_KEY_WR, {8'h00, KEY_SECOND});
         link_cmd(SPF_CMD_CTL_WR, (i == 2) ? 16'h8003 : 16'hc003);
         axi_rd(REG_STATUS, d, r);
         check("refused start flags", {d[16:15], d[13]}, 3'b001);
         check("no flash activity", n_fl, 0);
      end
      $display("test refused starts done");
      foreach (ops[k])
      begin
         for (int j = 0; j < ((k == 0) ? ROW_WORDS : 1); j++)
         begin
            // one field carries address and data, so each word holds its own address
            link_cmd(SPF_CMD_WR_LO, 16'h3c80 + 16'(2 * j));
            link_cmd(SPF_CMD_WR_HI, 16'h3c80 + 16'(2 * j));
         end
         check("loads leave array alone", n_fl, prev);
         // a doubled first key must still unlock
         if (k == 1)
            link_cmd(SPF_CMD_KEY_WR, {8'h00, KEY_FIRST});
         link_cmd(SPF_CMD_KEY_WR, {8'h00, KEY_FIRST});
         link_cmd(SPF_CMD_KEY_WR, {8'h00, KEY_SECOND});
         link_cmd(SPF_CMD_CTL_WR, ops[k]);
         axi_rd(REG_STATUS, d, r);
         check("busy and stalled", d[16:15], 2'b11);
         wait_idle();
         check("done clears flags", {d[16:15], d[13]}, 3'b000);
         check("operation code", fl_op, ops[k][3:0]);
         check("page in address", fl_pg, 8'h12);
         check("array touched", n_fl > prev, 1'b1);
         if (k < 2)
            check("words written", n_fl - prev, (k == 0) ? ROW_WORDS : 1);
         if (k < 2)
            check("last word written", fl_wd, (k == 0) ? 24'hfe3cfe : 24'h803c80);
         prev = n_fl;
      end
      $display("test program and erase done");
      wrap_up();
   end
endmodule : self_program_flash_sequencer_tb

// file: bench/spf_properties.sv
// link-level checks between the core end and the device end of the sequencer
`timescale 1ns/10ps
module spf_properties
   import spf_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        cmd_valid,
   input  wire spf_cmd_t    cmd,
   input  wire logic        byte_mode,
   input  wire logic [15:0] cmd_data,
   input  wire logic        stall,
   input  wire logic        rd_valid,
   input  wire logic [15:0] rd_data,
   input  wire logic [15:0] ctl_status
);
   // bench pulses osc_tick every clock, so busy time is counted in clocks
   localparam int BUSY_MIN = 11060;
   localparam int BUSY_MAX = 11070;
   logic [1:0]  key_q;
   logic [1:0]  key_d;
   logic [15:0] busy_q;
   logic [15:0] busy_d;
   logic        start_req;
   logic        keyed;
   logic        tbl_cmd;
   assign start_req = cmd_valid && cmd == SPF_CMD_CTL_WR && cmd_data[CTL_START_BIT];
   assign keyed     = key_q == 2'd2 && cmd_data[CTL_WEN_BIT];
   assign tbl_cmd   = cmd_valid && cmd inside {SPF_CMD_RD_LO, SPF_CMD_RD_HI, SPF_CMD_WR_LO, SPF_CMD_WR_HI};
   always_comb
   begin
      key_d  = key_q;
      busy_d = ctl_status[CTL_START_BIT] ? busy_q + 16'd1 : 16'd0;
      if (cmd_valid)
      begin
         if (cmd == SPF_CMD_KEY_WR && cmd_data[7:0] == KEY_FIRST)
            key_d = 2'd1;
         else if (cmd == SPF_CMD_KEY_WR && cmd_data[7:0] == KEY_SECOND && key_q == 2'd1)
            key_d = 2'd2;
         else
            key_d = 2'd0;
      end
   end
   always_ff @(posedge aclk)
   begin
      key_q  <= aresetn ? key_d : 2'd0;
      busy_q <= aresetn ? busy_d : 16'd0;
   end
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   AST_NO_CMD_IN_STALL: assert property (cmd_valid |-> !stall) else $error("command issued while stalled");
   AST_CMD_PULSE: assert property (cmd_valid |=> !cmd_valid) else $error("command strobe longer than one cycle");
   AST_TBL_STALL: assert property (tbl_cmd |=> ##[0:1] stall ##1 !stall) else $error("table op stall not one cycle");
   AST_RD_ANSWER: assert property (cmd_valid && cmd inside {SPF_CMD_RD_LO, SPF_CMD_RD_HI} |-> ##[1:3] rd_valid)
      else $error("table read gave no data");
   AST_RD_PULSE: assert property (rd_valid |=> !rd_valid) else $error("read data strobe too long");
   AST_BAD_START: assert property (start_req && !keyed |-> ##[1:3] (ctl_status[CTL_ERR_BIT] && !ctl_status[CTL_START_BIT]))
      else $error("unkeyed start not refused");
   AST_GOOD_START: assert property (start_req && keyed |-> ##[1:3] (ctl_status[CTL_START_BIT] && stall))
      else $error("keyed start did not launch");
   AST_BUSY_STALL: assert property (ctl_status[CTL_START_BIT] && $past(ctl_status[CTL_START_BIT]) |-> stall)
      else $error("busy without stall");
   AST_BUSY_LEN: assert property ($fell(ctl_status[CTL_START_BIT]) |-> busy_q >= BUSY_MIN && busy_q <= BUSY_MAX)
      else $error("operation length wrong");
   AST_DONE_CLR: assert property ($fell(ctl_status[CTL_START_BIT]) |-> !ctl_status[CTL_ERR_BIT] ##[0:2] !stall)
      else $error("completion did not clear flags");
   AST_RSVD_ZERO: assert property (ctl_status[12:7] == 6'h00 && ctl_status[5:4] == 2'h0)
      else $error("reserved control bits set");
endmodule : spf_properties

// file: hdl/spf_core.sv
// core end: takes commands from software over axi4-lite and drives the sequencer link
`timescale 1ns/10ps
module spf_core
   import spf_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   spf_if.core              link,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   logic            aw_q, aw_d, w_q, w_d;
   logic [7:0]      awa_q, awa_d;
   logic [31:0]     wd_q, wd_d;
   logic            bv_q, bv_d;
   logic [1:0]      br_q, br_d;
   logic            rv_q, rv_d;
   logic [31:0]     rd_q, rd_d;
   logic [1:0]      rr_q, rr_d;
   logic            cv_q, cv_d;
   spf_cmd_t        cmd_q, cmd_d;
   logic            bm_q, bm_d;
   logic [15:0]     cd_q, cd_d;
   logic [15:0]     rdata_q, rdata_d;
   logic            busy_q, busy_d;
   logic            awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;

   always_comb
   begin
      aw_d = aw_q; w_d = w_q; awa_d = awa_q; wd_d = wd_q;
      bv_d = bv_q; br_d = br_q; rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
      cv_d = 1'b0; cmd_d = cmd_q; bm_d = bm_q; cd_d = cd_q;
      rdata_d = link.rd_valid ? link.rd_data : rdata_q;
      busy_d  = busy_q && link.stall;
      if (s_axi_awvalid && !aw_q && !bv_q)
      begin
         aw_d  = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q && !bv_q)
      begin
         w_d  = 1'b1;
         wd_d = s_axi_wdata;
      end
      // a command only issues while the sequencer is not stalled
      if (aw_q && w_q && !link.stall && !busy_q)
      begin
         aw_d = 1'b0;
         w_d  = 1'b0;
         bv_d = 1'b1;
         br_d = 2'b00;
         if (awa_q == REG_CMD)
         begin
            cv_d   = 1'b1;
            busy_d = 1'b1;
            cmd_d  = spf_cmd_t'(wd_q[2:0]);
            bm_d   = wd_q[4];
            cd_d   = wd_q[31:16];
         end
         else
            br_d = 2'b10;
      end
      if (bv_q && s_axi_bready)
         bv_d = 1'b0;
      if (s_axi_arvalid && !rv_q)
      begin
         rv_d = 1'b1;
         rr_d = 2'b00;
         if (s_axi_araddr == REG_STATUS)
            rd_d = {15'h0000, link.stall, link.ctl_status};
         else if (s_axi_araddr == REG_RDATA)
            rd_d = {16'h0000, rdata_q};
         else
         begin
            rd_d = 32'h00000000;
            rr_d = 2'b10;
         end
      end
      else if (rv_q && s_axi_rready)
         rv_d = 1'b0;
      // readies are registered from the next state, so their timing is unchanged
      awrdy_d = !aw_d && !bv_d;
      wrdy_d  = !w_d && !bv_d;
      arrdy_d = !rv_d;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_q <= 1'b0; w_q <= 1'b0; awa_q <= '0; wd_q <= '0;
         bv_q <= 1'b0; br_q <= '0; rv_q <= 1'b0; rd_q <= '0; rr_q <= '0;
         cv_q <= 1'b0; cmd_q <= SPF_CMD_NONE; bm_q <= 1'b0; cd_q <= '0;
         rdata_q <= '0; busy_q <= 1'b0;
         awrdy_q <= 1'b1;
         wrdy_q  <= 1'b1;
         arrdy_q <= 1'b1;
      end
      else
      begin
         aw_q <= aw_d; w_q <= w_d; awa_q <= awa_d; wd_q <= wd_d;
         bv_q <= bv_d; br_q <= br_d; rv_q <= rv_d; rd_q <= rd_d; rr_q <= rr_d;
         cv_q <= cv_d; cmd_q <= cmd_d; bm_q <= bm_d; cd_q <= cd_d;
         rdata_q <= rdata_d; busy_q <= busy_d;
         awrdy_q <= awrdy_d;
         wrdy_q  <= wrdy_d;
         arrdy_q <= arrdy_d;
      end
   end

   assign s_axi_awready  = awrdy_q;
   assign s_axi_wready   = wrdy_q;
   assign s_axi_bvalid   = bv_q;
   assign s_axi_bresp    = br_q;
   assign s_axi_arready  = arrdy_q;
   assign s_axi_rvalid   = rv_q;
   assign s_axi_rdata    = rd_q;
   assign s_axi_rresp    = rr_q;
   assign link.cmd_valid = cv_q;
   assign link.cmd       = cmd_q;
   assign link.byte_mode = bm_q;
   assign link.cmd_data  = cd_q;
endmodule : spf_core

// file: hdl/spf_device.sv
// flash sequencer: holding buffer, table access, key unlock and timed program/erase
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module spf_device
   import spf_pkg::*;
(
   input  wire logic    aclk,
   input  wire logic    aresetn,
   spf_if.device        link,
   input  wire logic    osc_tick,
   output logic         flash_we,
   output logic         flash_erase,
   output logic [23:0]  flash_addr,
   output logic [23:0]  flash_wdata,
   output logic [3:0]   flash_op,
   input  wire logic [23:0] flash_rdata
);
   logic [WORD_W-1:0]     buf_q [ROW_WORDS];
   logic [PAGE_REG_W-1:0] page_q, page_d;
   logic [EA_W-1:0]       ea_q, ea_d;
   logic [15:0]           ctl_q, ctl_d;
   logic [1:0]            key_q, key_d;
   spf_state_t            st_q, st_d;
   logic [IDX_W-1:0]      widx_q, widx_d;
   logic                  rdv_q, rdv_d;
   logic [15:0]           rdd_q, rdd_d;
   logic                  tload;
   logic [CNT_W-1:0]      tcount;
   logic                  tdone;
   logic                  fwe_q, fwe_d, fer_q, fer_d;
   logic [ADDR_W-1:0]     fad_q, fad_d;
   logic [WORD_W-1:0]     fwd_q, fwd_d;
   logic                  buf_we;
   logic [IDX_W-1:0]      buf_idx;
   logic [WORD_W-1:0]     buf_wd;
   logic [ADDR_W-1:0]     tgt;
   logic                  is_erase;
   logic                  sdone_q, sdone_d;
   logic                  stall_q, stall_d;
   logic [3:0]            op;

   assign tgt      = {page_q, ea_q};
   assign is_erase = ctl_q[CTL_ERASE_BIT];
   assign op       = ctl_q[3:0];
   assign buf_idx  = IDX_W'((ea_q >> 1) % ROW_WORDS);

   spf_timer u_timer (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .load     (tload),
      .count    (tcount),
      .osc_tick (osc_tick),
      .done     (tdone)
   );

   always_comb
   begin
      page_d = page_q;
      ea_d   = ea_q;
      ctl_d  = ctl_q;
      key_d  = key_q;
      st_d   = st_q;
      widx_d = widx_q;
      rdv_d  = 1'b0;
      rdd_d  = rdd_q;
      tload  = 1'b0;
      tcount = CNT_W'(ROW_WRITE_CYC);
      fwe_d  = 1'b0;
      fer_d  = 1'b0;
      fad_d  = fad_q;
      fwd_d  = fwd_q;
      buf_we = 1'b0;
      buf_wd = buf_q[buf_idx];
      sdone_d = sdone_q;
      case (st_q)
         SPF_IDLE:
         begin
            if (link.cmd_valid)
            begin
               if (link.cmd != SPF_CMD_KEY_WR)
                  key_d = 2'd0;
               case (link.cmd)
                  SPF_CMD_PAGE:
                     page_d = link.cmd_data[7:0];
                  SPF_CMD_RD_LO, SPF_CMD_RD_HI, SPF_CMD_WR_LO, SPF_CMD_WR_HI:
                  begin
                     ea_d = link.cmd_data;
                     st_d = SPF_TBL;
                  end
                  SPF_CMD_KEY_WR:
                  begin
                     // a repeated first key restarts the pair instead of breaking it
                     if (link.cmd_data[7:0] == KEY_FIRST)
                        key_d = 2'd1;
                     else if (key_q == 2'd1 && link.cmd_data[7:0] == KEY_SECOND)
                        key_d = 2'd2;
                     else
                        key_d = 2'd0;
                  end
                  SPF_CMD_CTL_WR:
                  begin
                     ctl_d = (ctl_q & ~CTL_WR_MASK) | (link.cmd_data & CTL_WR_MASK);
                     key_d = 2'd0;
                     if (link.cmd_data[CTL_START_BIT])
                     begin
                        // an unkeyed or disabled start never reaches the array
                        if (key_q == 2'd2 && link.cmd_data[CTL_WEN_BIT])
                        begin
                           ctl_d[CTL_START_BIT] = 1'b1;
                           st_d  = SPF_BUSY;
                           tload   = 1'b1;
                           sdone_d = 1'b0;
                           fad_d   = tgt;
                           if (link.cmd_data[CTL_ERASE_BIT])
                           begin
                              if (link.cmd_data[3:0] == OP_CFG_ERASE)
                                 tcount = CNT_W'(CFG_ERASE_CYC);
                              else
                              begin
                                 tcount = CNT_W'(PAGE_ERASE_CYC);
                                 // two address units per word: a 1536-byte page spans 1024 units
                                 fad_d  = ADDR_W'((tgt / (2 * PAGE_WORDS)) * (2 * PAGE_WORDS));
                              end
                           end
                           else if (link.cmd_data[3:0] == OP_ROW_PROG)
                           begin
                              widx_d = '0;
                              fad_d  = ADDR_W'((tgt / (2 * ROW_WORDS)) * (2 * ROW_WORDS));
                           end
                           else
                              tcount = CNT_W'(WORD_WRITE_CYC);
                        end
                        else
                           ctl_d[CTL_ERR_BIT] = 1'b1;
                     end
                  end
                  default:
                     rdd_d = 16'h0000;
               endcase
            end
         end
         SPF_TBL:
         begin
            st_d  = SPF_IDLE;
            rdv_d = (link.cmd == SPF_CMD_RD_LO) || (link.cmd == SPF_CMD_RD_HI);
            case (link.cmd)
               SPF_CMD_RD_LO:
                  rdd_d = link.byte_mode ? {8'h00, (ea_q[0] ? flash_rdata[15:8] : flash_rdata[7:0])}
                                         : flash_rdata[15:0];
               SPF_CMD_RD_HI:
                  rdd_d = (link.byte_mode && ea_q[0]) ? 16'h0000 : {8'h00, flash_rdata[23:16]};
               SPF_CMD_WR_LO:
               begin
                  buf_we = 1'b1;
                  if (!link.byte_mode)
                     buf_wd[15:0] = link.cmd_data;
                  else if (ea_q[0])
                     buf_wd[15:8] = link.cmd_data[7:0];
                  else
                     buf_wd[7:0] = link.cmd_data[7:0];
               end
               SPF_CMD_WR_HI:
               begin
                  buf_we = !(link.byte_mode && ea_q[0]);
                  buf_wd[23:16] = link.cmd_data[7:0];
               end
               default:
                  rdd_d = rdd_q;
            endcase
         end
         SPF_BUSY:
         begin
            fer_d = is_erase;
            if (!is_erase && op == OP_ROW_PROG)
            begin
               // stream the held row one word per clock, exactly one row, then stay quiet
               fwe_d   = !sdone_q;
               fwd_d   = buf_q[widx_q];
               fad_d   = fwe_q ? fad_q + 24'h000002 : fad_q;
               widx_d  = widx_q + 6'd1;
               sdone_d = sdone_q || (widx_q == IDX_W'(ROW_WORDS - 1));
            end
            else if (!is_erase)
            begin
               // one write pulse, so the cell is not rewritten for the whole timed span
               fwe_d   = !sdone_q;
               fwd_d   = buf_q[buf_idx];
               sdone_d = 1'b1;
            end
            if (tdone)
            begin
               st_d                = SPF_IDLE;
               fwe_d               = 1'b0;
               fer_d               = 1'b0;
               ctl_d[CTL_START_BIT] = 1'b0;
               ctl_d[CTL_ERR_BIT]   = 1'b0;
            end
         end
         default:
            st_d = SPF_IDLE;
      endcase
      stall_d = (st_d != SPF_IDLE);
   end

   always_ff @(posedge aclk)
   begin
      if (buf_we)
         buf_q[buf_idx] <= buf_wd;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         page_q <= '0;
         ea_q   <= '0;
         ctl_q  <= CTL_RESET;
         key_q  <= 2'd0;
         st_q   <= SPF_IDLE;
         widx_q <= '0;
         rdv_q  <= 1'b0;
         rdd_q  <= '0;
         fwe_q  <= 1'b0;
         fer_q  <= 1'b0;
         fad_q  <= '0;
         fwd_q  <= '0;
         sdone_q <= 1'b0;
         stall_q <= 1'b0;
      end
      else
      begin
         page_q <= page_d;
         ea_q   <= ea_d;
         ctl_q  <= ctl_d;
         key_q  <= key_d;
         st_q   <= st_d;
         widx_q <= widx_d;
         rdv_q  <= rdv_d;
         rdd_q  <= rdd_d;
         fwe_q  <= fwe_d;
         fer_q  <= fer_d;
         fad_q  <= fad_d;
         fwd_q  <= fwd_d;
         sdone_q <= sdone_d;
         stall_q <= stall_d;
      end
   end

   assign link.stall      = stall_q;
   assign link.rd_valid   = rdv_q;
   assign link.rd_data    = rdd_q;
   assign link.ctl_status = ctl_q;
   assign flash_we        = fwe_q;
   assign flash_erase     = fer_q;
   assign flash_addr      = fad_q;
   assign flash_wdata     = fwd_q;
   assign flash_op        = op;
endmodule : spf_device

// file: hdl/spf_if.sv
// core-to-sequencer link: one command strobe, stall and read data
`timescale 1ns/10ps
interface spf_if (input wire logic aclk);
   import spf_pkg::*;
   logic            cmd_valid;
   spf_cmd_t        cmd;
   logic            byte_mode;
   logic [15:0]     cmd_data;
   logic            stall;
   logic            rd_valid;
   logic [15:0]     rd_data;
   logic [15:0]     ctl_status;
   modport device (input cmd_valid, cmd, byte_mode, cmd_data, output stall, rd_valid, rd_data, ctl_status);
   modport core   (output cmd_valid, cmd, byte_mode, cmd_data, input stall, rd_valid, rd_data, ctl_status);
endinterface : spf_if

// file: hdl/spf_pkg.sv
// shared constants and types for the flash self-programming sequencer
package spf_pkg;
   localparam int          ROW_WORDS      = 64;
   localparam int          ROW_BYTES      = 192;
   localparam int          PAGE_ROWS      = 8;
   localparam int          PAGE_WORDS     = 512;
   localparam int          PAGE_BYTES     = 1536;
   localparam int          ADDR_W         = 24;
   localparam int          WORD_W         = 24;
   localparam int          IDX_W          = 6;
   localparam int          PAGE_REG_W     = 8;
   localparam int          EA_W           = 16;
   localparam int          TBL_WRITE_CYC  = 2;
   // self-timed durations, in fast rc oscillator cycles
   localparam int          ROW_WRITE_CYC  = 11064;
   localparam int          WORD_WRITE_CYC = 11064;
   localparam int          PAGE_ERASE_CYC = 11064;
   localparam int          CFG_ERASE_CYC  = 11064;
   localparam int          CNT_W          = 16;
   // flash control register fields
   localparam int          CTL_START_BIT  = 15;
   localparam int          CTL_WEN_BIT    = 14;
   localparam int          CTL_ERR_BIT    = 13;
   localparam int          CTL_ERASE_BIT  = 6;
   localparam logic [15:0] CTL_WR_MASK    = 16'h404f;
   localparam logic [15:0] CTL_RESET      = 16'h0000;
   localparam logic [7:0]  KEY_FIRST      = 8'h55;
   localparam logic [7:0]  KEY_SECOND     = 8'haa;
   localparam logic [3:0]  OP_CFG_ERASE   = 4'h0;
   localparam logic [3:0]  OP_PAGE_ERASE  = 4'h2;
   localparam logic [3:0]  OP_WORD_PROG   = 4'h3;
   localparam logic [3:0]  OP_ROW_PROG    = 4'h1;
   // core-side command codes
   typedef enum logic [2:0] {
      SPF_CMD_NONE   = 3'b000,
      SPF_CMD_RD_LO  = 3'b001,
      SPF_CMD_RD_HI  = 3'b010,
      SPF_CMD_WR_LO  = 3'b011,
      SPF_CMD_WR_HI  = 3'b100,
      SPF_CMD_CTL_WR = 3'b101,
      SPF_CMD_KEY_WR = 3'b110,
      SPF_CMD_PAGE   = 3'b111
   } spf_cmd_t;
   typedef enum logic [1:0] {
      SPF_IDLE  = 2'b00,
      SPF_TBL   = 2'b01,
      SPF_BUSY  = 2'b10
   } spf_state_t;
   // master-side register offsets
   localparam logic [7:0]  REG_CMD        = 8'h00;
   localparam logic [7:0]  REG_DATA       = 8'h04;
   localparam logic [7:0]  REG_STATUS     = 8'h08;
   localparam logic [7:0]  REG_RDATA      = 8'h0c;
endpackage : spf_pkg

// file: hdl/spf_timer.sv
// self-timed operation counter on fast rc oscillator ticks
`timescale 1ns/10ps
module spf_timer
   import spf_pkg::*;
(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] count,
   input  wire logic             osc_tick,
   output logic                  done
);
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic             run_q, run_d;
   logic             done_q, done_d;

   always_comb
   begin
      cnt_d  = cnt_q;
      run_d  = run_q;
      done_d = 1'b0;
      if (load)
      begin
         cnt_d = count;
         run_d = 1'b1;
      end
      else if (run_q && osc_tick)
      begin
         if (cnt_q <= 16'h0001)
         begin
            run_d  = 1'b0;
            done_d = 1'b1;
         end
         cnt_d = cnt_q - 16'h0001;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_q  <= '0;
         run_q  <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         cnt_q  <= cnt_d;
         run_q  <= run_d;
         done_q <= done_d;
      end
   end

   assign done = done_q;
endmodule : spf_timer
